// ### design/emb_memory_block.sv
// one embedded synchronous memory block with page decoder and local outputs
`timescale 1ns/1ps
module emb_memory_block #(
	parameter logic [1:0] PAGE_ID = 2'h0    // page this block answers to
) (
	input  wire logic        I_CORE_CLK,    // global clock
	input  wire logic        I_RESET_N,     // async reset, active low
	input  wire logic [2:0]  I_SHAPE,       // depth by width selection
	input  wire logic        I_DEEP_EN,     // block stacked on shared line
	input  wire logic [12:0] I_ADDR,        // word address, page in top bits
	input  wire logic [15:0] I_WDATA,       // write data, low bits used
	input  wire logic        I_WREQ,        // write request
	input  wire logic [15:0] I_LINE_IN,     // shared line level from column
	output logic      [15:0] O_RDATA,       // registered read data
	output logic      [15:0] O_LINE_OUT,    // drive value for shared line
	output logic             O_LINE_OE,     // high while block drives line
	output logic      [9:0]  O_LOCAL        // local routing outputs
);
	// flat bit store; every shape views it as words of its own width
	logic [emb_pkg::TOTAL_BITS-1:0]  mem_r;

	// page 0 owns the column while reset holds, so the line never floats
	localparam logic OE_RST = (PAGE_ID == emb_pkg::PAGE_OWNER_RST);

	// output flops and their next values
	logic [emb_pkg::MAX_WIDTH-1:0]   rdata_r;
	logic [emb_pkg::MAX_WIDTH-1:0]   line_r;
	logic                            oe_r;
	logic [emb_pkg::LOCAL_LINES-1:0] local_r;
	logic [emb_pkg::MAX_WIDTH-1:0]   rdata_nxt;
	logic [emb_pkg::MAX_WIDTH-1:0]   line_nxt;
	logic                            oe_nxt;
	logic [emb_pkg::LOCAL_LINES-1:0] local_nxt;

	// address fields
	logic [emb_pkg::PAGE_AW-1:0]     word_addr;
	logic [emb_pkg::PAGE_W-1:0]      page_sel;
	logic [emb_pkg::PAGE_AW-1:0]     waddr;

	// shape and page decode
	logic [4:0]                      width;
	logic                            page_hit;
	logic                            we;

	// per-lane view of the addressed word
	logic [emb_pkg::MAX_WIDTH-1:0]   lane_on;
	logic [emb_pkg::MAX_WIDTH-1:0]   lane_we;
	logic [emb_pkg::PAGE_AW-1:0]     lane_idx [emb_pkg::MAX_WIDTH];
	logic [emb_pkg::MAX_WIDTH-1:0]   rd_word;

	// column level is only watched; the array never reads it back
	logic                            unused_line;

	// bit index of the first bit of the addressed word for a shape
	function automatic logic [10:0] word_base(
		input logic [2:0]  s,
		input logic [10:0] a
	);
		word_base = 11'h000;
		unique case (s)
			emb_pkg::SHAPE_128X16: begin
				word_base = {a[6:0], 4'h0};
			end
			emb_pkg::SHAPE_256X8: begin
				word_base = {a[7:0], 3'h0};
			end
			emb_pkg::SHAPE_512X4: begin
				word_base = {a[8:0], 2'h0};
			end
			emb_pkg::SHAPE_1024X2: begin
				word_base = {a[9:0], 1'h0};
			end
			default: begin
				word_base = a;
			end
		endcase
	endfunction : word_base

	// word width of a shape; unused codes fall back to one bit
	function automatic logic [4:0] word_width(
		input logic [2:0] s
	);
		word_width = 5'h01;
		unique case (s)
			emb_pkg::SHAPE_128X16: begin
				word_width = 5'h10;
			end
			emb_pkg::SHAPE_256X8: begin
				word_width = 5'h08;
			end
			emb_pkg::SHAPE_512X4: begin
				word_width = 5'h04;
			end
			emb_pkg::SHAPE_1024X2: begin
				word_width = 5'h02;
			end
			default: begin
				word_width = 5'h01;
			end
		endcase
	endfunction : word_width

	// page compare; a lone block always answers
	function automatic logic page_match(
		input logic                       deep,
		input logic [emb_pkg::PAGE_W-1:0] pg
	);
		page_match = !deep || (pg == PAGE_ID);
	endfunction : page_match

	// array bit of lane l for a word starting at bit b
	function automatic logic [10:0] lane_index(
		input logic [10:0] b,
		input logic [4:0]  l
	);
		lane_index = b + {6'h00, l};
	endfunction : lane_index

	// low bits address the array, top bits choose the page
	assign word_addr = I_ADDR[emb_pkg::PAGE_AW-1:0];
	assign page_sel  = I_ADDR[emb_pkg::PAGE_MSB:emb_pkg::PAGE_LSB];
	assign width     = word_width(I_SHAPE);
	assign waddr     = word_base(I_SHAPE, word_addr);

	// stacked blocks decode the page, so only one owns a word
	assign page_hit  = page_match(I_DEEP_EN, page_sel);
	// strobe made here; user logic only meets clock setup and hold
	assign we        = I_WREQ && page_hit;

	genvar g;

	generate
		for (g = 0; g < emb_pkg::MAX_WIDTH; g++) begin : g_lane
			// lane g is bit g of the word, present only below the shape width
			assign lane_on[g]  = (5'(g) < width);
			assign lane_idx[g] = lane_index(waddr, 5'(g));
			assign lane_we[g]  = we && lane_on[g];
			// bits beyond the shape width read as zero
			assign rd_word[g]  = lane_on[g] ? mem_r[lane_idx[g]] : 1'b0;
		end
	endgenerate

	// store is not reset: contents are undefined until written
	always_ff @(posedge I_CORE_CLK) begin
		for (int i = 0; i < emb_pkg::MAX_WIDTH; i++) begin
			if (lane_we[i]) begin
				mem_r[lane_idx[i]] <= I_WDATA[i];
			end
		end
	end

	// read-first: a write shows the old word for one cycle
	assign rdata_nxt = rd_word;
	assign line_nxt  = rd_word;
	assign oe_nxt    = page_hit;

	generate
		for (g = 0; g < emb_pkg::LOCAL_UNIQUE; g++) begin : g_local
			assign local_nxt[g] = rd_word[g];
		end
	endgenerate
	// tenth line repeats bit 0 for product-term feedback
	assign local_nxt[emb_pkg::LOCAL_LINES-1] = rd_word[0];

	// read data to the wide routing
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rdata_r <= emb_pkg::RDATA_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// value offered to the shared column line
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			line_r <= emb_pkg::RDATA_RST;
		end else begin
			line_r <= line_nxt;
		end
	end

	// driver enable; exactly one page matches, so no contention
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			oe_r <= OE_RST;
		end else begin
			oe_r <= oe_nxt;
		end
	end

	// fast lines to the neighbouring cells
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			local_r <= emb_pkg::LOCAL_RST;
		end else begin
			local_r <= local_nxt;
		end
	end

	// every output straight from its flop
	assign O_RDATA    = rdata_r;
	assign O_LINE_OUT = line_r;
	assign O_LINE_OE  = oe_r;
	assign O_LOCAL    = local_r;

	// line input kept for observation only
	assign unused_line = ^I_LINE_IN;
endmodule : emb_memory_block

// ### design/emb_pkg.sv
// package of constants for the embedded synchronous memory block
package emb_pkg;
	localparam int PAGE_DEPTH   = 2048;
	localparam int PAGE_AW      = 11;
	localparam int TOTAL_BITS   = 2048;
	localparam int MAX_WIDTH    = 16;
	localparam int SHAPE_W      = 3;
	localparam int LOCAL_LINES  = 10;
	localparam int LOCAL_UNIQUE = 9;
	localparam int PAGE_W       = 2;
	localparam logic [2:0] SHAPE_128X16  = 3'h0;
	localparam logic [2:0] SHAPE_256X8   = 3'h1;
	localparam logic [2:0] SHAPE_512X4   = 3'h2;
	localparam logic [2:0] SHAPE_1024X2  = 3'h3;
	localparam logic [2:0] SHAPE_2048X1  = 3'h4;
	localparam logic [15:0] RDATA_RST    = 16'h0000;
	localparam logic [9:0]  LOCAL_RST    = 10'h000;
	localparam int PAGE_LSB     = 11;
	localparam int PAGE_MSB     = 12;
	localparam logic [1:0]  PAGE_OWNER_RST = 2'h0;
endpackage : emb_pkg

// ### test/emb_memory_block_props.sv
// port checker for the memory block
`timescale 1ns/1ps
module emb_props (
	input wire logic        I_CORE_CLK,  // global clock
	input wire logic        I_RESET_N,   // async reset, active low
	input wire logic [2:0]  I_SHAPE,     // shape selection
	input wire logic        I_DEEP_EN,   // stacked mode
	input wire logic [12:0] I_ADDR,      // word and page address
	input wire logic [15:0] I_WDATA,     // write data
	input wire logic        I_WREQ,      // write request
	input wire logic [15:0] O_RDATA,     // read data
	input wire logic [15:0] O_LINE_OUT,  // line drive value
	input wire logic        O_LINE_OE,   // line drive enable
	input wire logic [9:0]  O_LOCAL      // local outputs
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence s_wr_lone16;
		I_WREQ && !I_DEEP_EN && (I_SHAPE == 3'h0);
	endsequence
	sequence s_hold_addr;
		!I_WREQ && $stable(I_ADDR) && $stable(I_SHAPE);
	endsequence
	property p_wr; s_wr_lone16 ##1 s_hold_addr |=> (O_RDATA == $past(I_WDATA, 2)); endproperty
	a_wr: assert property (p_wr) else $error("written word not read back");
	property p_hit; I_DEEP_EN && I_ADDR[12:11] == 2'h0 |=> O_LINE_OE; endproperty
	a_hit: assert property (p_hit) else $error("own page not driving");
	property p_line; O_LINE_OE |-> (O_LINE_OUT == O_RDATA); endproperty
	a_line: assert property (p_line) else $error("line value differs");
	property p_narrow; I_SHAPE == 3'h4 |=> (O_RDATA[15:1] == 15'h0000); endproperty
	a_narrow: assert property (p_narrow) else $error("bits above width set");
	property p_oe; !I_DEEP_EN |=> O_LINE_OE; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_pg; I_DEEP_EN && I_ADDR[12:11]!=2'h0 |=> !O_LINE_OE; endproperty
	a_pg: assert property (p_pg) else $error("pg");
	property p_lc; O_LOCAL=={O_RDATA[0], O_RDATA[8:0]}; endproperty
	a_lc: assert property (p_lc) else $error("lc");
endmodule : emb_props
bind emb_memory_block emb_props i_props(.*);

// ### test/emb_user.sv
// column line as user logic sees it
`timescale 1ns/1ps
module emb_user(input wire logic i_oe, input wire logic [15:0] i_out, output logic [15:0] o_ln);
	assign o_ln=i_oe ? i_out : ~i_out;
endmodule : emb_user

// ### test/test_emb_memory_block.sv
// bench for the memory block
`timescale 1ns/1ps
`define CHK(x,e) begin checks_done++; if ((x)!==(e)) begin errors++; \
	$display("wrong value %0t %h %h", $time, x, e); end end
module test_emb_memory_block;
	logic c=0, r=0, p=0, w=0, oe;
	logic [2:0] s=3'h0;
	logic [12:0] a=13'h9;
	logic [15:0] d=16'h0, ln, q, lo;
	logic [9:0] lc;
	int errors=0, checks_done=0;
	always #5 c=~c;
	emb_memory_block i_dut(.I_CORE_CLK(c), .I_RESET_N(r), .I_SHAPE(s), .I_DEEP_EN(p),
		.I_ADDR(a), .I_WDATA(d), .I_WREQ(w), .I_LINE_IN(ln), .O_RDATA(q),
		.O_LINE_OUT(lo), .O_LINE_OE(oe), .O_LOCAL(lc));
	emb_user i_user(.i_oe(oe), .i_out(lo), .o_ln(ln));
	task automatic cy(logic x, logic [15:0] v); @(negedge c); {w, d}={x, v}; endtask : cy
	task automatic t_shape;
		for (int i=0; i<5; i++) begin
			s=i[2:0]; cy(1, 16'ha5c3); cy(0, 16'h0); cy(0, 16'h0);
			`CHK(q, 16'ha5c3 & ((16'h1<<(16>>i))-16'h1))
		end
		$display("shapes done");
	endtask : t_shape
	task automatic t_page;
		s=3'h0; cy(1, 16'h1111); cy(1, 16'h2222); cy(0, 16'h0);
		`CHK(q, 16'h1111)
		p=1; a=13'h0809; cy(1, 16'h3333); cy(0, 16'h0);
		`CHK(oe, 1'b0)
		a=13'h9; cy(0, 16'h0);
		`CHK(ln, 16'h2222)
		`CHK(oe, 1'b1)
		`CHK(lc, 10'h022)
		$display("pages done");
	endtask : t_page
	task complete_run;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors==0 && checks_done>0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin repeat (3) @(negedge c); r=1; t_shape; t_page; complete_run; end
endmodule : test_emb_memory_block
